// ==== logic/pcsan_page_regs.sv ====
// Behaviour
// - bit 15 of every page register shows whether more pages follow
// - bit 14 of received pages shows the partner acknowledged our code word
// - received base page bits 13:12 carry the partner fault code
// - received base page bits 8:7 carry the partner pause ability
// - received base page bit 6 shows partner half-duplex support
// - received base page bit 5 shows partner full-duplex support
// - reserved bits are read-only, read zero; software writes zero there
// - received next page bit 13 shows message versus unformatted page
// - next page bit 12 shows whether the sender can comply
// - next page bit 11 is read-only and inverts the previous toggle
// - next page bits 10:0 hold the code; writable in the transmit page
// - a captured partner page sets the page-received expansion bit
`timescale 1ns/1ps
`default_nettype none
`include "pcsan_regs.svh"

module pcsan_page_regs #(
  parameter int ADDR_W = 12,
  parameter bit NEXT_PAGE_ABLE = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire pcsan_pkg::pcsan_page_evt_t rx_page,
  input wire logic tx_page_take,
  output logic [15:0] tx_page,
  output logic tx_page_pending,
  output logic irq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (ADDR_W < 10) begin : g_addr_check
    $error("pcsan_page_regs: ADDR_W must be at least 10");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  pcsan_pkg::pcsan_reg_acc_t acc;
  logic [7:0] acc_index;
  logic [31:0] rdata;
  logic hit;

  logic [15:0] base_rx;
  logic [15:0] next_rx;
  logic [15:0] tx_next;
  logic exp_page_rx;
  logic [`PCSAN_IRQ_W-1:0] irq_status;
  logic [`PCSAN_IRQ_W-1:0] irq_mask;
  logic [`PCSAN_IRQ_W-1:0] irq_event;
  logic [`PCSAN_IRQ_W-1:0] next_irq_status;

  logic rd_status;
  logic rd_expansion;
  logic wr_tx;
  logic wr_mask;
  logic base_capture;
  logic next_capture;
  logic tx_taken;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  pcsan_apb_slave #(
    .ADDR_W(ADDR_W)
  ) u_apb (
    .clk(clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .acc(acc),
    .acc_index(acc_index),
    .rdata(rdata),
    .hit(hit)
  );

  // ****************************************************************
  // access strobes
  // ****************************************************************
  assign rd_status = acc.rd && (acc.index == `PCSAN_IDX_IRQ_STATUS);
  assign rd_expansion = acc.rd && (acc.index == `PCSAN_IDX_EXPANSION);
  assign wr_tx = acc.wr && (acc.index == `PCSAN_IDX_TX_NEXT);
  assign wr_mask = acc.wr && (acc.index == `PCSAN_IDX_IRQ_MASK);

  assign base_capture = rx_page.valid && rx_page.is_base;
  assign next_capture = rx_page.valid && !rx_page.is_base;
  assign tx_taken = tx_page_take;

  // ****************************************************************
  // address decode and read mux
  // ****************************************************************
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    unique case (acc_index)
      `PCSAN_IDX_BASE_RX: begin
        rdata = {16'h0, base_rx};
      end
      `PCSAN_IDX_EXPANSION: begin
        rdata[`PCSAN_EXP_PAGE_RX] = exp_page_rx;
        rdata[`PCSAN_EXP_NP_ABLE] = NEXT_PAGE_ABLE;
      end
      `PCSAN_IDX_TX_NEXT: begin
        rdata = {16'h0, tx_next};
      end
      `PCSAN_IDX_NEXT_RX: begin
        rdata = {16'h0, next_rx};
      end
      `PCSAN_IDX_IRQ_STATUS: begin
        rdata[`PCSAN_IRQ_W-1:0] = irq_status;
      end
      `PCSAN_IDX_IRQ_MASK: begin
        rdata[`PCSAN_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // received base page
  // ****************************************************************
  // reserved bits 11:9 and 4:0 are masked to zero on capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base_rx <= `PCSAN_RX_RESET;
    end else if (base_capture) begin
      base_rx <= rx_page.word & `PCSAN_BASE_RX_MASK;
    end
  end

  // ****************************************************************
  // received next page
  // ****************************************************************
  // toggle arrives as sent, which is the inverse of the previous one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      next_rx <= `PCSAN_RX_RESET;
    end else if (next_capture) begin
      next_rx <= rx_page.word & `PCSAN_NEXT_RX_MASK;
    end
  end

  // ****************************************************************
  // expansion page-received indication
  // ****************************************************************
  // clear on read only once reported, a new capture wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      exp_page_rx <= 1'b0;
    end else if (rx_page.valid) begin
      exp_page_rx <= 1'b1;
    end else if (rd_expansion && prdata[`PCSAN_EXP_PAGE_RX]) begin
      exp_page_rx <= 1'b0;
    end
  end

  // ****************************************************************
  // transmit next page, writable fields and toggle
  // ****************************************************************
  // bits 15, 13, 12 and 10:0 from software; 14 stays zero
  // toggle flips each time a page is taken; software writes never reach it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_next <= `PCSAN_TX_RESET;
    end else begin
      if (wr_tx) begin
        tx_next[`PCSAN_BIT_NEXT_PAGE] <= acc.wdata[`PCSAN_BIT_NEXT_PAGE];
        tx_next[`PCSAN_BIT_ACK] <= 1'b0;
        tx_next[`PCSAN_BIT_MESSAGE] <= acc.wdata[`PCSAN_BIT_MESSAGE];
        tx_next[`PCSAN_BIT_ACK2] <= acc.wdata[`PCSAN_BIT_ACK2];
        tx_next[`PCSAN_CODE_HI:`PCSAN_CODE_LO] <= acc.wdata[`PCSAN_CODE_HI:`PCSAN_CODE_LO];
      end
      if (tx_taken) begin
        tx_next[`PCSAN_BIT_TOGGLE] <= !tx_next[`PCSAN_BIT_TOGGLE];
      end
    end
  end

  // ****************************************************************
  // transmit page to the link
  // ****************************************************************
  // the word handed out carries the toggle current at the take
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_page <= `PCSAN_TX_RESET;
    end else if (tx_taken) begin
      tx_page <= tx_next;
    end
  end

  // pending from software load until taken, a load wins over a take
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_page_pending <= 1'b0;
    end else if (wr_tx) begin
      tx_page_pending <= 1'b1;
    end else if (tx_taken) begin
      tx_page_pending <= 1'b0;
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  always_comb begin
    irq_event = '0;
    irq_event[`PCSAN_IRQ_BASE_RX] = base_capture;
    irq_event[`PCSAN_IRQ_NEXT_RX] = next_capture;
    irq_event[`PCSAN_IRQ_TX_TAKEN] = tx_taken;
  end

  // read clears only the bits it reported, an event in the same cycle survives
  always_comb begin
    next_irq_status = (irq_status & ~(rd_status ? prdata[`PCSAN_IRQ_W-1:0] : '0)) | irq_event;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= `PCSAN_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask <= `PCSAN_IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask <= acc.wdata[`PCSAN_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule

`default_nettype wire

// ==== include/pcsan_regs.svh ====
`ifndef PCSAN_REGS_SVH
`define PCSAN_REGS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PCSAN_IDX_BASE_RX 8'h05
`define PCSAN_IDX_EXPANSION 8'h06
`define PCSAN_IDX_TX_NEXT 8'h07
`define PCSAN_IDX_NEXT_RX 8'h08
`define PCSAN_IDX_IRQ_STATUS 8'h10
`define PCSAN_IDX_IRQ_MASK 8'h11

// ****************************************************************
// page field positions
// ****************************************************************
`define PCSAN_BIT_NEXT_PAGE 15
`define PCSAN_BIT_ACK 14
`define PCSAN_BIT_FAULT_HI 13
`define PCSAN_BIT_FAULT_LO 12
`define PCSAN_BIT_PAUSE_HI 8
`define PCSAN_BIT_PAUSE_LO 7
`define PCSAN_BIT_HALF_DUPLEX 6
`define PCSAN_BIT_FULL_DUPLEX 5
`define PCSAN_BIT_MESSAGE 13
`define PCSAN_BIT_ACK2 12
`define PCSAN_BIT_TOGGLE 11
`define PCSAN_CODE_HI 10
`define PCSAN_CODE_LO 0

// ****************************************************************
// masks and reset values
// ****************************************************************
`define PCSAN_BASE_RX_MASK 16'hf1e0
`define PCSAN_NEXT_RX_MASK 16'hffff
`define PCSAN_TX_WR_MASK 16'hb7ff
`define PCSAN_TX_RESET 16'h2001
`define PCSAN_RX_RESET 16'h0000

// ****************************************************************
// expansion and interrupt bits
// ****************************************************************
`define PCSAN_EXP_PAGE_RX 1
`define PCSAN_EXP_NP_ABLE 2
`define PCSAN_IRQ_W 3
`define PCSAN_IRQ_BASE_RX 0
`define PCSAN_IRQ_NEXT_RX 1
`define PCSAN_IRQ_TX_TAKEN 2
`define PCSAN_IRQ_RESET 3'h0

`endif

// ==== include/pcsan_pkg.sv ====
`default_nettype none

package pcsan_pkg;

  // a page code word arriving from the partner
  typedef struct packed {
    logic valid;
    logic is_base;
    logic [15:0] word;
  } pcsan_page_evt_t;

  // a completed register access from the bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [31:0] wdata;
  } pcsan_reg_acc_t;

  typedef enum logic [0:0] {
    apb_idle,
    apb_answer
  } pcsan_apb_state_t;

endpackage

`default_nettype wire

// ==== logic/pcsan_apb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

module pcsan_apb_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output pcsan_pkg::pcsan_reg_acc_t acc,
  output logic [7:0] acc_index,
  input wire logic [31:0] rdata,
  input wire logic hit
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (ADDR_W < 10) begin : g_addr_check
    $error("pcsan_apb_slave: ADDR_W must be at least 10");
  end

  pcsan_pkg::pcsan_apb_state_t state;
  logic aligned;
  logic full_hit;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign acc_index = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 10) == '0);
  assign full_hit = aligned && hit;

  // one wait state, access completes while pready is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= pcsan_pkg::apb_idle;
    end else begin
      unique case (state)
        pcsan_pkg::apb_idle: begin
          if (psel && penable) begin
            state <= pcsan_pkg::apb_answer;
          end
        end
        pcsan_pkg::apb_answer: begin
          state <= pcsan_pkg::apb_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (state == pcsan_pkg::apb_idle && psel && penable) begin
      pready <= 1'b1;
      prdata <= (full_hit && !pwrite) ? rdata : 32'h0;
      pslverr <= !full_hit;
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  // access strobe at the completing edge only
  always_comb begin
    acc.wr = (state == pcsan_pkg::apb_answer) && psel && penable && pwrite && full_hit;
    acc.rd = (state == pcsan_pkg::apb_answer) && psel && penable && !pwrite && full_hit;
    acc.index = paddr[9:2];
    acc.wdata = pwdata;
  end

endmodule

`default_nettype wire

// ==== dv/pcsan_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// bus, link and irq checks
// ****
module pcsan_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire pcsan_pkg::pcsan_page_evt_t rx_page,
  input wire logic tx_page_take,
  input wire logic [15:0] tx_page,
  input wire logic tx_page_pending,
  input wire logic irq
);
  logic tog;
  wire ev = rx_page.valid | tx_page_take | pready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) tog <= 1'b0;
    else if (tx_page_take) tog <= ~tog;
  end
  a_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_idle_data: assert property (!pready || pslverr |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_tx_toggle: assert property (tx_page_take |=> tx_page[11] == $past(tog))
    else $error("toggle wrong");
  a_tx_steady: assert property (!tx_page_take |=> $stable(tx_page))
    else $error("tx page moved");
  a_tx_rsvd: assert property (tx_page[14] == 1'b0) else $error("bit14 set");
  a_take_clear: assert property (tx_page_take && !(pready && pwrite) |=> !tx_page_pending)
    else $error("pending kept");
  a_irq_cause: assert property ($rose(irq) |-> $past(ev) || $past(ev, 2))
    else $error("irq without cause");
  a_irq_clear: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("irq fell alone");
  cover property (tx_page_take);
  cover property (rx_page.valid && rx_page.is_base);
  cover property (pready && pslverr);
endmodule

bind pcsan_page_regs pcsan_checker #(.ADDR_W(ADDR_W)) pcsan_checker_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .rx_page(rx_page), .tx_page_take(tx_page_take),
  .tx_page(tx_page), .tx_page_pending(tx_page_pending), .irq(irq)
);
`default_nettype wire

// ==== dv/pcsan_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// remote link partner
// ****
module pcsan_link_model (
  input wire logic clk,
  output pcsan_pkg::pcsan_page_evt_t rx_page,
  output logic tx_page_take
);
  initial begin
    rx_page = '0;
    tx_page_take = 1'b0;
  end
  task automatic send(input logic base, input logic [15:0] w);
    @(posedge clk);
    rx_page <= {1'b1, base, w};
    @(posedge clk);
    rx_page <= {1'b0, base, ~w};
  endtask
  task automatic take();
    @(posedge clk);
    tx_page_take <= 1'b1;
    @(posedge clk);
    tx_page_take <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/pcsan_page_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pcsan_regs.svh"
// ****
// page register bench
// ****
module pcsan_page_regs_tb;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic tx_page_take, tx_page_pending, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tx_page, w;
  pcsan_pkg::pcsan_page_evt_t rx_page;
  int mismatches, checked;
  pcsan_page_regs pcsan_page_regs_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_page(rx_page),
    .tx_page_take(tx_page_take), .tx_page(tx_page),
    .tx_page_pending(tx_page_pending), .irq(irq));
  pcsan_link_model pcsan_link_model_i (.clk(clk), .rx_page(rx_page),
    .tx_page_take(tx_page_take));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i[7:0], 2'b00};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, ba(i), 32'h0);
    chk(n, rd, e);
  endtask
  task automatic later(output logic [31:0] v);
    repeat (2) @(posedge clk);
    #1;
    v = 32'(irq);
  endtask
  task automatic t_reset();
    rdchk("base", `PCSAN_IDX_BASE_RX, 32'h0);
    rdchk("exp", `PCSAN_IDX_EXPANSION, 32'h4);
    rdchk("tx", `PCSAN_IDX_TX_NEXT, 32'h2001);
    rdchk("next", `PCSAN_IDX_NEXT_RX, 32'h0);
    rdchk("mask", `PCSAN_IDX_IRQ_MASK, 32'h0);
    chk("txpage", 32'(tx_page), 32'h2001);
    $display("done reset");
  endtask
  task automatic t_base();
    for (int i = 0; i < 4; i++) begin
      w = {i[0], i[1], i[1:0], 3'b111, i[1:0], i[0], ~i[0], 5'h1f};
      pcsan_link_model_i.send(1'b1, w);
      rdchk("base", `PCSAN_IDX_BASE_RX, {16'h0, w & 16'hf1e0});
    end
    rdchk("exp", `PCSAN_IDX_EXPANSION, 32'h6);
    rdchk("exp", `PCSAN_IDX_EXPANSION, 32'h4);
    for (int i = 0; i < 2; i++) begin
      w = i ? 16'h5a5a : 16'ha5a5;
      pcsan_link_model_i.send(1'b0, w);
      rdchk("next", `PCSAN_IDX_NEXT_RX, {16'h0, w});
    end
    $display("done rx pages");
  endtask
  task automatic t_tx();
    apb(1'b1, ba(`PCSAN_IDX_TX_NEXT), 32'hffff);
    #1;
    chk("pend", 32'(tx_page_pending), 32'h1);
    rdchk("tx", `PCSAN_IDX_TX_NEXT, 32'hb7ff);
    pcsan_link_model_i.take();
    #1;
    chk("txpage", 32'(tx_page), 32'hb7ff);
    chk("pend", 32'(tx_page_pending), 32'h0);
    rdchk("tx", `PCSAN_IDX_TX_NEXT, 32'hbfff);
    pcsan_link_model_i.take();
    #1;
    chk("txpage", 32'(tx_page), 32'hbfff);
    rdchk("tx", `PCSAN_IDX_TX_NEXT, 32'hb7ff);
    $display("done tx page");
  endtask
  task automatic t_irq();
    rdchk("st", `PCSAN_IDX_IRQ_STATUS, 32'h7);
    rdchk("st", `PCSAN_IDX_IRQ_STATUS, 32'h0);
    apb(1'b1, ba(`PCSAN_IDX_IRQ_MASK), 32'h5);
    rdchk("mask", `PCSAN_IDX_IRQ_MASK, 32'h5);
    pcsan_link_model_i.send(1'b0, 16'h0123);
    later(rd);
    chk("irq", rd, 32'h0);
    pcsan_link_model_i.take();
    later(rd);
    chk("irq", rd, 32'h1);
    rdchk("st", `PCSAN_IDX_IRQ_STATUS, 32'h6);
    later(rd);
    chk("irq", rd, 32'h0);
    pcsan_link_model_i.send(1'b1, 16'h4021);
    later(rd);
    chk("irq", rd, 32'h1);
    rdchk("st", `PCSAN_IDX_IRQ_STATUS, 32'h1);
    $display("done irq");
  endtask
  task automatic t_err();
    apb(1'b0, 12'h024, 32'h0);
    chk("err", 32'(err), 32'h1);
    chk("rd", rd, 32'h0);
    apb(1'b1, 12'h01d, 32'h0);
    chk("err", 32'(err), 32'h1);
    apb(1'b1, ba(`PCSAN_IDX_BASE_RX), 32'hffff);
    chk("err", 32'(err), 32'h0);
    rdchk("base", `PCSAN_IDX_BASE_RX, 32'h4020);
    rdchk("tx", `PCSAN_IDX_TX_NEXT, 32'hbfff);
    $display("done errors");
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    mismatches = 0;
    checked = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_base();
    t_tx();
    t_irq();
    t_err();
    close_out();
  end
endmodule
`default_nettype wire
